// file: common/exec_pkg.sv
// Purpose: Shared constants and types for the integer execution datapath
// Assumes: Single clock domain, 32-bit or 64-bit register width
// Notes:   Operation codes are local to this block
package exec_pkg;

    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int XLEN           = 64;
    localparam int IMM_W          = 12;
    localparam int WORD_W         = 32;
    localparam int SHAMT_W32      = 5;
    localparam int SHAMT_W64      = 6;
    localparam int STORE_BYTES    = 4;

    // -------------------------------------------------------------------
    // Instruction field positions for the split store offset
    // -------------------------------------------------------------------
    localparam int UPPER_INSN_HI  = 31;
    localparam int UPPER_INSN_LO  = 25;
    localparam int LOWER_INSN_HI  = 11;
    localparam int LOWER_INSN_LO  = 7;

    // -------------------------------------------------------------------
    // Operation selector
    // -------------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_SLTIU = 4'h0,
        OP_SLTU  = 4'h1,
        OP_SRA   = 4'h2,
        OP_SRL   = 4'h3,
        OP_SUB   = 4'h4,
        OP_XOR   = 4'h5,
        OP_SW    = 4'h6,
        OP_SRAW  = 4'h7,
        OP_SRLW  = 4'h8,
        OP_SUBW  = 4'h9
    } op_t;

    // Store sequence states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_XLAT = 4'h2,
        ST_ADDR = 4'h4,
        ST_DATA = 4'h8
    } store_state_t;

endpackage : exec_pkg

// file: hw/alu_unit.sv
// Purpose: Combinational compare, shift, subtract and xor unit
// Assumes: Operands already read from the register file
// Notes:   Result is registered by the caller
module alu_unit
    import exec_pkg::*;
(
    // Operation and configuration
    input  wire op_t                  op,
    input  wire logic                 is_rv64,
    // Operands
    input  wire logic [XLEN-1:0]      src1,
    input  wire logic [XLEN-1:0]      src2,
    input  wire logic [IMM_W-1:0]     short_immediate_field,
    // Result
    output logic      [XLEN-1:0]      result
);

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Sign extend a 32-bit word to the register width
    function automatic logic [XLEN-1:0] sext_word(input logic [WORD_W-1:0] w);
        sext_word = {{(XLEN-WORD_W){w[WORD_W-1]}}, w};
    endfunction : sext_word

    logic [XLEN-1:0]      imm_ext;
    logic [SHAMT_W64-1:0] shamt;
    logic [XLEN-1:0]      a_view;
    logic [WORD_W-1:0]    w_sra;
    logic [WORD_W-1:0]    w_srl;
    logic [WORD_W-1:0]    w_sub;

    // Immediate is sign extended, then compared without sign
    assign imm_ext = {{(XLEN-IMM_W){short_immediate_field[IMM_W-1]}},
                      short_immediate_field};                          // RQ1
    // Five shift bits in 32-bit mode, six in 64-bit mode
    assign shamt   = is_rv64 ? src2[SHAMT_W64-1:0]
                             : {1'b0, src2[SHAMT_W32-1:0]};            // RQ4 RQ5
    // In 32-bit mode the value sits sign extended so the sign bit is right
    assign a_view  = is_rv64 ? src1 : sext_word(src1[WORD_W-1:0]);
    // Word forms look only at the low half of each input
    assign w_sra = WORD_W'($signed(src1[WORD_W-1:0]) >>> src2[SHAMT_W32-1:0]); // RQ13
    assign w_srl = src1[WORD_W-1:0] >> src2[SHAMT_W32-1:0];                // RQ13
    assign w_sub = src1[WORD_W-1:0] - src2[WORD_W-1:0];                    // RQ13

    // -------------------------------------------------------------------
    // Result select
    // -------------------------------------------------------------------
    always_comb begin
        result = '0;
        unique case (op)
            OP_SLTIU: result = {{(XLEN-1){1'b0}}, (src1 < imm_ext)};        // RQ2
            OP_SLTU:  result = {{(XLEN-1){1'b0}}, (src1 < src2)};           // RQ3
            OP_SRA: begin
                result = XLEN'($signed(a_view) >>> shamt);                  // RQ4
            end
            OP_SRL: begin
                result = is_rv64 ? (src1 >> shamt)
                                 : XLEN'(src1[WORD_W-1:0] >> shamt);        // RQ5
            end
            OP_SUB:   result = src1 - src2;                                 // RQ6
            OP_XOR:   result = src1 ^ src2;                                 // RQ7
            OP_SRAW:  result = sext_word(w_sra);                            // RQ13
            OP_SRLW:  result = sext_word(w_srl);                            // RQ13
            OP_SUBW:  result = sext_word(w_sub);                            // RQ13
            default:  result = '0;
        endcase
    end

endmodule : alu_unit

// file: hw/int_exec.sv
// Purpose: Integer execution slice for compare, shift, subtract, xor and store word
// Assumes: Decoder holds its request until accepted; one operation at a time
// Notes:   ALU results are written one cycle after acceptance
//
// How it works
// [RQ1] Immediate sign extended, compared without sign
// [RQ2] Immediate compare writes one or zero
// [RQ3] Register compare unsigned, zero-extended single bit
// [RQ4] Arithmetic right shift, low five/six bits
// [RQ5] Logical right shift fills zeros
// [RQ6] Subtract wraps, no overflow flag
// [RQ7] Xor writes bitwise exclusive or
// [RQ8] Store address is source plus offset
// [RQ9] Store writes low 32 bits only
// [RQ10] Announce four bytes, then send data
// [RQ11] Failures raise exception with virtual address
// [RQ12] Offset from insn bits 31:25, 11:7
// [RQ13] Word forms sign extend 32-bit result
module int_exec
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // Decoder request
    input  wire logic                 op_valid,
    output logic                      op_ready,
    input  wire exec_pkg::op_t        op_sel,
    input  wire logic                 is_rv64,
    input  wire logic [31:0]          insn,
    input  wire logic [4:0]           rd_idx,
    // Register file read values
    input  wire logic [exec_pkg::XLEN-1:0] src1_val,
    input  wire logic [exec_pkg::XLEN-1:0] src2_val,
    // Register file write port
    output logic                      rd_we,
    output logic      [4:0]           rd_waddr,
    output logic      [exec_pkg::XLEN-1:0] rd_wdata,
    // Address translation
    output logic                      xlat_req,
    output logic      [exec_pkg::XLEN-1:0] xlat_vaddr,
    input  wire logic                 xlat_done,
    input  wire logic                 xlat_fail,
    input  wire logic [exec_pkg::XLEN-1:0] xlat_paddr,
    // Memory interface
    output logic                      mem_ea_req,
    output logic      [exec_pkg::XLEN-1:0] mem_paddr,
    output logic      [3:0]           mem_size,
    input  wire logic                 mem_ea_done,
    input  wire logic                 mem_ea_exc,
    output logic                      mem_wr_req,
    output logic      [exec_pkg::WORD_W-1:0] mem_wdata,
    input  wire logic                 mem_wr_done,
    input  wire logic                 mem_wr_exc,
    // Retire status
    output logic                      retire_ok,
    output logic                      mem_exc,
    output logic      [exec_pkg::XLEN-1:0] exc_vaddr
);

    // -------------------------------------------------------------------
    // Reset synchroniser
    // -------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n;

    // Release is synchronised so all flops leave reset on the same edge
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // -------------------------------------------------------------------
    // Operand shaping
    // -------------------------------------------------------------------
    logic [IMM_W-1:0]  short_immediate_field;
    logic [IMM_W-1:0]  store_offset;
    logic [6:0]        store_offset_upper_field;
    logic [4:0]        store_offset_lower_field;
    logic [XLEN-1:0]   store_vaddr;
    logic [XLEN-1:0]   s1_eff;
    logic [XLEN-1:0]   alu_result;

    assign short_immediate_field    = insn[31:20];
    assign store_offset_upper_field = insn[UPPER_INSN_HI:UPPER_INSN_LO];    // RQ12
    assign store_offset_lower_field = insn[LOWER_INSN_HI:LOWER_INSN_LO];    // RQ12
    assign store_offset = {store_offset_upper_field, store_offset_lower_field}; // RQ12
    // In 32-bit mode only the low word of the base is meaningful
    assign s1_eff = is_rv64 ? src1_val
                            : {{(XLEN-WORD_W){1'b0}}, src1_val[WORD_W-1:0]};
    // Address wraps at register width; 32-bit mode keeps it in the low word
    always_comb begin
        store_vaddr = s1_eff + {{(XLEN-IMM_W){store_offset[IMM_W-1]}},
                                store_offset};                              // RQ8
        if (!is_rv64) begin
            store_vaddr = {{(XLEN-WORD_W){1'b0}}, store_vaddr[WORD_W-1:0]};
        end
    end

    // -------------------------------------------------------------------
    // Datapath units
    // -------------------------------------------------------------------
    alu_unit u_alu (
        .op                    (op_sel),
        .is_rv64               (is_rv64),
        .src1                  (src1_val),
        .src2                  (src2_val),
        .short_immediate_field (short_immediate_field),
        .result                (alu_result)
    );

    logic store_busy;
    logic store_start;
    logic store_ok;

    assign store_start = op_valid && op_ready && (op_sel == OP_SW);

    store_unit u_store (
        .core_clk    (core_clk),
        .rst_sync_n  (rst_sync_n),
        .start       (store_start),
        .vaddr       (store_vaddr),
        .wdata       (src2_val[WORD_W-1:0]),                                // RQ9
        .xlat_req    (xlat_req),
        .xlat_vaddr  (xlat_vaddr),
        .xlat_done   (xlat_done),
        .xlat_fail   (xlat_fail),
        .xlat_paddr  (xlat_paddr),
        .mem_ea_req  (mem_ea_req),
        .mem_paddr   (mem_paddr),
        .mem_size    (mem_size),
        .mem_ea_done (mem_ea_done),
        .mem_ea_exc  (mem_ea_exc),
        .mem_wr_req  (mem_wr_req),
        .mem_wdata   (mem_wdata),
        .mem_wr_done (mem_wr_done),
        .mem_wr_exc  (mem_wr_exc),
        .busy        (store_busy),
        .done_ok     (store_ok),
        .mem_exc     (mem_exc),
        .exc_vaddr   (exc_vaddr)
    );

    // Stall the decoder while a store is in flight or its outcome is pending
    assign op_ready = rst_sync_n && !store_busy && !store_ok && !mem_exc;

    // -------------------------------------------------------------------
    // Register write-back
    // -------------------------------------------------------------------
    // Stores write no destination; everything else writes the selected result
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_we    <= 1'b0;
            rd_waddr <= '0;
            rd_wdata <= '0;
        end else begin
            rd_we <= op_valid && op_ready && (op_sel != OP_SW);
            if (op_valid && op_ready && (op_sel != OP_SW)) begin
                rd_waddr <= rd_idx;
                rd_wdata <= alu_result;                 // RQ2 RQ3 RQ6 RQ7 RQ13
            end
        end
    end

    // Retire pulse: ALU write or a store that finished cleanly
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            retire_ok <= 1'b0;
        end else begin
            retire_ok <= (op_valid && op_ready && (op_sel != OP_SW)) || store_ok; // RQ11
        end
    end

endmodule : int_exec

// file: hw/store_unit.sv
// Purpose: Store-word sequencer toward the memory interface
// Assumes: Translator and memory answer with one-cycle done pulses
// Notes:   Announcement of four bytes always precedes the data
module store_unit
    import exec_pkg::*;
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_sync_n,
    // Request
    input  wire logic                 start,
    input  wire logic [XLEN-1:0]      vaddr,
    input  wire logic [WORD_W-1:0]    wdata,
    // Translator
    output logic                      xlat_req,
    output logic      [XLEN-1:0]      xlat_vaddr,
    input  wire logic                 xlat_done,
    input  wire logic                 xlat_fail,
    input  wire logic [XLEN-1:0]      xlat_paddr,
    // Memory
    output logic                      mem_ea_req,
    output logic      [XLEN-1:0]      mem_paddr,
    output logic      [3:0]           mem_size,
    input  wire logic                 mem_ea_done,
    input  wire logic                 mem_ea_exc,
    output logic                      mem_wr_req,
    output logic      [WORD_W-1:0]    mem_wdata,
    input  wire logic                 mem_wr_done,
    input  wire logic                 mem_wr_exc,
    // Outcome
    output logic                      busy,
    output logic                      done_ok,
    output logic                      mem_exc,
    output logic      [XLEN-1:0]      exc_vaddr
);

    store_state_t state_r;
    logic [WORD_W-1:0] data_r;

    // Requests are levels held while in each state
    assign xlat_req   = (state_r == ST_XLAT);
    assign mem_ea_req = (state_r == ST_ADDR);
    assign mem_wr_req = (state_r == ST_DATA);
    assign busy       = (state_r != ST_IDLE);
    assign mem_size   = 4'(STORE_BYTES);                                   // RQ10

    // -------------------------------------------------------------------
    // Sequence: translate, announce, write
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: if (start) state_r <= ST_XLAT;
                ST_XLAT: if (xlat_done) state_r <= xlat_fail ? ST_IDLE : ST_ADDR; // RQ11
                ST_ADDR: if (mem_ea_done) state_r <= mem_ea_exc ? ST_IDLE : ST_DATA; // RQ10 RQ11
                ST_DATA: if (mem_wr_done) state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Operands captured at start so the data stay fixed through the sequence
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xlat_vaddr <= '0;
            data_r     <= '0;
            mem_paddr  <= '0;
        end else begin
            if (state_r == ST_IDLE && start) begin
                xlat_vaddr <= vaddr;
                data_r     <= wdata;                                        // RQ9
            end
            if (state_r == ST_XLAT && xlat_done && !xlat_fail) begin
                mem_paddr <= xlat_paddr;                                    // RQ10
            end
        end
    end
    assign mem_wdata = data_r;                                              // RQ10

    // Outcome pulses; a failure reports the virtual address
    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            done_ok   <= 1'b0;
            mem_exc   <= 1'b0;
            exc_vaddr <= '0;
        end else begin
            done_ok <= (state_r == ST_DATA) && mem_wr_done && !mem_wr_exc;
            mem_exc <= ((state_r == ST_XLAT) && xlat_done && xlat_fail)
                     | ((state_r == ST_ADDR) && mem_ea_done && mem_ea_exc)
                     | ((state_r == ST_DATA) && mem_wr_done && mem_wr_exc); // RQ11
            if (busy) begin
                exc_vaddr <= xlat_vaddr;                                    // RQ11
            end
        end
    end

endmodule : store_unit

// file: testbench/int_exec_assertions.sv
// Purpose: Port-level checks of the execution slice
// Assumes: Stores in 64-bit mode only
// Notes:   Operands captured at acceptance, judged a cycle later
module exec_checker
    import exec_pkg::*;
(
    // Clock, reset and request
    input                core_clk,
    input                rst_n,
    input                op_valid,
    input                op_ready,
    input exec_pkg::op_t op_sel,
    input                is_rv64,
    input [31:0]         insn,
    input [4:0]          rd_idx,
    input [XLEN-1:0]     src1_val,
    input [XLEN-1:0]     src2_val,
    // Results and memory side
    input                rd_we,
    input [4:0]          rd_waddr,
    input [XLEN-1:0]     rd_wdata,
    input                xlat_req,
    input [XLEN-1:0]     xlat_vaddr,
    input                xlat_done,
    input                xlat_fail,
    input                mem_ea_req,
    input [3:0]          mem_size,
    input                mem_wr_req,
    input [WORD_W-1:0]   mem_wdata,
    input                retire_ok,
    input                mem_exc,
    input [XLEN-1:0]     exc_vaddr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic            acc;
    logic [XLEN-1:0] s1_r;
    logic [XLEN-1:0] s2_r;
    logic [XLEN-1:0] si_r;
    logic [XLEN-1:0] sv_r;
    logic [XLEN-1:0] sra_w;
    assign acc = op_valid && op_ready;
    // Signed operand keeps the shift arithmetic
    assign sra_w = $signed(s1_r) >>> s2_r[5:0];
    // Operands held from acceptance through a store
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {s1_r, s2_r, si_r, sv_r} <= '0;
        end else if (acc) begin
            s1_r <= src1_val;
            s2_r <= src2_val;
            si_r <= {{52{insn[31]}}, insn[31:20]};
            sv_r <= src1_val + {{52{insn[31]}}, insn[31:25], insn[11:7]};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_alu_write_next: assert property (
        acc && op_sel != OP_SW |=> rd_we && retire_ok && rd_waddr == $past(rd_idx))
        else $error("write missing");
    a_sltiu_value: assert property (
        acc && op_sel == OP_SLTIU && is_rv64 |=> rd_wdata == {63'h0, s1_r < si_r})
        else $error("imm compare");
    a_sltu_value: assert property (
        acc && op_sel == OP_SLTU && is_rv64 |=> rd_wdata == {63'h0, s1_r < s2_r})
        else $error("reg compare");
    a_sra_value: assert property (
        acc && op_sel == OP_SRA && is_rv64 |=> rd_wdata == sra_w)
        else $error("sra wrong");
    a_sub_value: assert property (
        acc && op_sel == OP_SUB && is_rv64 |=> rd_wdata == s1_r - s2_r)
        else $error("subtract wrong");
    a_xor_value: assert property (
        acc && op_sel == OP_XOR && is_rv64 |=> rd_wdata == (s1_r ^ s2_r))
        else $error("xor wrong");
    a_store_vaddr: assert property (
        $rose(xlat_req) |-> xlat_vaddr == sv_r)
        else $error("bad address");
    a_size_four: assert property (
        mem_ea_req |-> mem_size == 4'h4)
        else $error("size not four");
    a_wr_after_ea: assert property (
        $rose(mem_wr_req) |-> $past(mem_ea_req))
        else $error("write unannounced");
    a_wr_low_word: assert property (
        mem_wr_req |-> mem_wdata == s2_r[31:0])
        else $error("bad data");
    a_fail_to_exc: assert property (
        xlat_req && xlat_done && xlat_fail |=> mem_exc && !retire_ok && !mem_ea_req)
        else $error("fault lost");
    a_exc_vaddr: assert property (
        mem_exc |-> exc_vaddr == sv_r && !retire_ok)
        else $error("bad exc address");
endmodule : exec_checker

bind int_exec exec_checker exec_checker_inst (.*);

// file: testbench/mem_partner.sv
// Purpose: Translator and memory model for the store sequencer
// Assumes: One request level at a time, answered by one-cycle pulses
// Notes:   fail_stage 1, 2, 3 faults translation, announcement, data write
module mem_partner
    import exec_pkg::*;
#(
    parameter logic [XLEN-1:0] PA_OFS = 64'h0000_0001_0000_0000
)(
    // Clock, reset and test controls
    input                   core_clk,
    input                   rst_n,
    input  [3:0]            delay,
    input  [1:0]            fail_stage,
    // Requests from the slice
    input                   xlat_req,
    input  [XLEN-1:0]       xlat_vaddr,
    input                   mem_ea_req,
    input                   mem_wr_req,
    // Answers
    output logic            xlat_done,
    output logic            xlat_fail,
    output logic [XLEN-1:0] xlat_paddr,
    output logic            mem_ea_done,
    output logic            mem_ea_exc,
    output logic            mem_wr_done,
    output logic            mem_wr_exc
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] wait_r;
    logic       ans;
    assign ans = xlat_done | mem_ea_done | mem_wr_done;
    // Wait, then pulse; the address is scrambled outside its answer cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {xlat_done, xlat_fail, mem_ea_done, mem_ea_exc, mem_wr_done, mem_wr_exc,
             xlat_paddr, wait_r} <= '0;
        end else begin
            {xlat_done, xlat_fail, mem_ea_done, mem_ea_exc, mem_wr_done, mem_wr_exc} <= '0;
            xlat_paddr <= ~xlat_paddr;
            wait_r <= 4'h0;
            if (!ans && (xlat_req || mem_ea_req || mem_wr_req)) begin
                if (wait_r != delay) begin
                    wait_r <= wait_r + 4'h1;
                end else if (xlat_req) begin
                    xlat_done <= 1'b1;
                    xlat_fail <= fail_stage == 2'h1;
                    xlat_paddr <= xlat_vaddr + PA_OFS;
                end else if (mem_ea_req) begin
                    mem_ea_done <= 1'b1;
                    mem_ea_exc <= fail_stage == 2'h2;
                end else begin
                    mem_wr_done <= 1'b1;
                    mem_wr_exc <= fail_stage == 2'h3;
                end
            end
        end
    end
endmodule : mem_partner

// file: testbench/tb_int_compare_shift_sub_xor_store.sv
// Purpose: Self-checking bench for the execution slice
// Assumes: Inputs change at the falling edge; stores in 64-bit mode
// Notes:   Results are judged at the falling edge after acceptance
module tb_int_compare_shift_sub_xor_store;
    timeunit 1ns;
    timeprecision 100ps;
    import exec_pkg::*;
    localparam logic [63:0] PA_OFS = 64'h0000_0001_0000_0000;
    logic core_clk, rst_n, op_valid, is_rv64, op_ready, rd_we, retire_ok, mem_exc;
    logic xlat_req, xlat_done, xlat_fail, mem_ea_req, mem_ea_done, mem_ea_exc;
    logic mem_wr_req, mem_wr_done, mem_wr_exc;
    op_t         op_sel;
    logic [31:0] insn, mem_wdata;
    logic [4:0]  rd_idx, rd_waddr;
    logic [3:0]  delay, mem_size;
    logic [1:0]  fail_stage;
    logic [63:0] src1_val, src2_val, rd_wdata, xlat_vaddr, xlat_paddr, mem_paddr, exc_vaddr;
    int          miscompares = 0, checks = 0;

    int_exec int_exec_inst (.*);
    mem_partner #(.PA_OFS(PA_OFS)) mem_partner_inst (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [63:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run

    // Reference model
    function automatic logic [63:0] expect_of(input op_t op, input logic rv,
        input logic [63:0] a, b, input logic [31:0] i);
        logic signed [63:0] sa;
        logic signed [31:0] sw;
        sa = $signed(a) >>> b[5:0];
        case (op)
            OP_SLTIU: return {63'h0, a < {{52{i[31]}}, i[31:20]}};
            OP_SLTU:  return {63'h0, a < b};
            OP_SRA:   return rv ? sa : {32'h0, $signed(a[31:0]) >>> b[4:0]};
            OP_SRL:   return rv ? a >> b[5:0] : {32'h0, a[31:0] >> b[4:0]};
            OP_SUB:   return a - b;
            OP_XOR:   return a ^ b;
            OP_SRAW:  sw = $signed(a[31:0]) >>> b[4:0];
            OP_SRLW:  sw = a[31:0] >> b[4:0];
            default:  sw = a[31:0] - b[31:0];
        endcase
        return {{32{sw[31]}}, sw};
    endfunction : expect_of

    // ALU op; valid stays up between calls
    task automatic do_alu(input op_t op, input logic [63:0] a, b,
        input logic [31:0] i = 32'h0, input logic rv = 1'b1);
        logic [63:0] e;
        e = expect_of(op, rv, a, b, i);
        op_sel = op;
        {is_rv64, src1_val, src2_val, insn} = {rv, a, b, i};
        rd_idx = rd_idx + 5'h1;
        op_valid = 1'b1;
        check(op_ready, 1'b1);
        @(negedge core_clk);
        check({rd_we, retire_ok, rd_waddr}, {2'b11, rd_idx});
        check(rv ? rd_wdata : {32'h0, rd_wdata[31:0]}, rv ? e : {32'h0, e[31:0]});
    endtask : do_alu

    task automatic end_ops;
        op_valid = 1'b0;
        @(negedge core_clk);
    endtask : end_ops

    // One store, judged per stage; ready returns with the retire pulse
    task automatic do_store(input logic [63:0] a, b, input logic [31:0] i,
        input logic [3:0] dly, input logic [1:0] fail);
        logic [63:0] va;
        logic        ea_seen, wr_seen, fin;
        va = a + {{52{i[31]}}, i[31:25], i[11:7]};
        {ea_seen, wr_seen, fin} = 3'b000;
        op_sel = OP_SW;
        {delay, fail_stage, is_rv64, src1_val, src2_val, insn} = {dly, fail, 1'b1, a, b, i};
        op_valid = 1'b1;
        @(negedge core_clk);
        op_valid = 1'b0;
        for (int n = 0; n < 40 && !fin; n++) begin
            check(op_ready, retire_ok);
            if (mem_ea_req) begin
                ea_seen = 1'b1;
                check(mem_paddr, va + PA_OFS);
                check(mem_size, 4'h4);
            end
            if (mem_wr_req) begin
                wr_seen = ea_seen;
                check(mem_wdata, b[31:0]);
            end
            fin = retire_ok | mem_exc;
            if (!fin) @(negedge core_clk);
        end
        check({retire_ok, mem_exc}, fail == 2'h0 ? 2'b10 : 2'b01);
        check({ea_seen, wr_seen}, {fail != 2'h1, fail == 2'h0 || fail == 2'h3});
        if (fail != 2'h0) check(exc_vaddr, va);
        @(negedge core_clk);
    endtask : do_store

    task automatic alu_ops;
        do_alu(OP_SLTIU, 64'hFFFF_FFFF_FFFF_F7FF, 64'h0, 32'h8000_0000);
        do_alu(OP_SLTIU, 64'hFFFF_FFFF_FFFF_F800, 64'h0, 32'h8000_0000);
        do_alu(OP_SLTIU, 64'h0000_0000_0000_07FE, 64'h0, 32'h7FF0_0000);
        do_alu(OP_SLTU, 64'h1, 64'h8000_0000_0000_0000);
        do_alu(OP_SLTU, 64'h8000_0000_0000_0000, 64'h1);
        do_alu(OP_SUB, 64'h0, 64'h1);
        do_alu(OP_XOR, 64'hF0F0_1234_0000_FFFF, 64'h0FF0_4321_FFFF_0000);
        do_alu(OP_SRAW, 64'h1234_5678_8000_0000, 64'h24);
        do_alu(OP_SRLW, 64'h0000_0000_8000_0000, 64'h0);
        do_alu(OP_SUBW, 64'h0000_0001_0000_0000, 64'h1);
        // Amount 0x25 is 5 in 32-bit mode, 37 in 64-bit mode
        for (int m = 0; m < 2; m++) begin
            do_alu(OP_SRA, 64'h8123_4567_89AB_CDEF, 64'hFFFF_FFFF_FFFF_FFE5, 32'h0, m[0]);
            do_alu(OP_SRL, 64'h8123_4567_89AB_CDEF, 64'hFFFF_FFFF_FFFF_FFE5, 32'h0, m[0]);
            do_alu(OP_SRA, 64'h8000_0000_8000_0001, 64'h3F, 32'h0, m[0]);
        end
        end_ops();
    endtask : alu_ops

    task automatic stores;
        do_store(64'h0000_0000_1000_0000, 64'hDEAD_BEEF_1234_5678, 32'hFE00_0800, 4'h0, 2'h0);
        do_store(64'hFFFF_FFFF_FFFF_FFF0, 64'h0BAD_F00D_CAFE_0001, 32'h240F_F500, 4'h3, 2'h0);
        for (int f = 1; f < 4; f++) do_store(64'h2000, 64'h5A5A, 32'hFE00_0F80, 4'h1, f[1:0]);
        do_alu(OP_XOR, 64'h1, 64'h3);
        end_ops();
    endtask : stores

    initial begin
        {rst_n, op_valid, is_rv64, delay, fail_stage} = '0;
        op_sel = OP_XOR;
        {insn, rd_idx, src1_val, src2_val} = '0;
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        alu_ops();
        stores();
        complete_run();
    end

    // Watchdog: the whole run needs under a hundred cycles
    initial begin
        #50000;
        miscompares++;
        complete_run();
    end
endmodule : tb_int_compare_shift_sub_xor_store
